/* File: logic/power_monitor_adc_sequencer.sv */
// converter sequencer of a digital power monitor: mode, status, channel config, calibration
// assumes a register port decoded by the serial interface and a converter giving sample_data
//
// Overview of operation
// - mode bit 6 set powers converter down; cleared runs it; powered after reset.
// - mode bit 5 set holds converter idle, acquiring nothing.
// - after a triggered cycle go idle, or power down if bit 4 set.
// - mode bit 3 zero means one triggered cycle, one means continuous.
// - each mode register write with bits 6 and 5 clear starts a new measurement cycle.
// - mode field bits 2..0 select which inputs are measured.
// - continuous mode keeps cycling the selected inputs without host action.
// - ready flag low during conversion, high once all results are stored.
// - ready flag only meaningful in triggered acquisition.
// - every mode register write clears the ready flag.
// - overflow flag set when current or power results exceed range.
// - shunt config holds aux time bits 9..7, primary time bits 2..0.
// - time codes give 64, 128, 256, 512 us, then 1.024 and 2.048 ms.
// - averaging fields set sample count; only the average is stored.
// - averaging codes 0..11 give two to the code samples, 11xx gives 4096.
// - nonzero calibration gain computes primary current and power results.
// - shunt result is signed, 2.5 uV per step, 80 mV full scale.
// - current math uses 11-bit resolution; host writes 15-bit gain.
`timescale 1ns/1ps
`default_nettype none
module power_monitor_adc_sequencer
  import pm_seq_pkg::*;
#(
  parameter int conv_base_cycles = CONV_BASE_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic signed [15:0] sample_data,
  output logic [15:0] reg_rdata_q,
  output logic converter_power_down_q,
  output logic conv_busy_q,
  output logic [2:0] conv_input_q,
  output logic sample_take_q,
  output logic [15:0] current_result_q,
  output logic [15:0] power_result_q,
  output logic conversion_ready_flag_q,
  output logic math_overflow_flag_q
);

  // input set chosen by the operating mode field
  function automatic logic [4:0] mode_mask(input logic [2:0] m);
    case (m)
      3'h0: return 5'h01;
      3'h1: return 5'h02;
      3'h2: return 5'h03;
      3'h3: return 5'h04;
      3'h4: return 5'h08;
      3'h5: return 5'h0C;
      3'h6: return 5'h10;
      default: return 5'h1F;
    endcase
  endfunction

  // first selected step at or after start, bit 3 marks found
  function automatic logic [3:0] next_from(input logic [4:0] mask, input logic [3:0] start);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 4; i >= 0; i--) begin
      if (mask[i] && 4'(i) >= start) r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  // conversion time code to doubling count of the base time
  function automatic logic [2:0] ct_shift(input logic [2:0] code);
    return code[2] ? (code[1] ? 3'h5 : 3'h4) : {1'b0, code[1:0]};
  endfunction

  // averaging code to log2 of the sample count
  function automatic logic [3:0] avg_shift(input logic [3:0] code);
    return (code[3:2] == 2'h3) ? AVG_MAX_SHIFT : code;
  endfunction

  state_e state_q;
  logic [7:0] mode_q;
  logic [15:0] cal_q, icfg_q;
  logic [2:0] step_q;
  logic [23:0] tick_q;
  logic [12:0] samp_q;
  logic signed [27:0] acc_q;
  logic [15:0] res_q [5];
  logic [15:0] rd_val;

  // register write decode, reserved bits dropped
  wire mode_wr = reg_wr && reg_addr == ADDR_MODE;
  wire [7:0] mode_new = reg_wdata[7:0] & MODE_MASK;
  wire [4:0] sel_mask = mode_mask(mode_q[2:0]);
  wire [3:0] first_new = next_from(mode_mask(mode_new[2:0]), 4'h0);
  wire [3:0] first_cur = next_from(sel_mask, 4'h0);
  wire [3:0] nxt = next_from(sel_mask, {1'b0, step_q} + 4'h1);

  // per-step time and averaging, shunt steps from their own fields
  wire [2:0] ct_code = (step_q == STEP_PSHUNT) ? icfg_q[2:0] :
    (step_q == STEP_ASHUNT) ? icfg_q[9:7] : FIXED_CT_CODE;
  wire [3:0] avg_code = (step_q == STEP_PSHUNT) ? icfg_q[6:3] :
    (step_q == STEP_ASHUNT) ? icfg_q[13:10] : 4'h0;
  wire [23:0] step_cycles = 24'(conv_base_cycles) << ct_shift(ct_code);
  wire [3:0] avg_sh = avg_shift(avg_code);
  wire [12:0] samp_last = 13'((32'h1 << avg_sh) - 32'h1);
  wire conv_end = state_q == ST_CONV && tick_q >= step_cycles - 24'h1; // shorter time ends step
  wire last_samp = samp_q >= samp_last; // smaller count ends averaging

  // accumulate and average; shunt samples are signed 2.5 uV steps
  wire signed [27:0] acc_sum = acc_q + 28'(sample_data);
  wire signed [27:0] avg_full = acc_sum >>> avg_sh;

  // current with 11-bit math resolution, power from current and bus
  wire signed [31:0] cur_prod = $signed(res_q[STEP_PSHUNT]) * $signed({1'b0, cal_q[14:0]});
  wire signed [31:0] cur_full = cur_prod >>> MATH_RES_SHIFT;
  wire cur_ovf = cur_full[31:15] != {17{cur_full[15]}};
  wire signed [39:0] pow_prod = $signed(cur_full[15:0]) * $signed({1'b0, res_q[STEP_PBUS]});
  wire signed [39:0] pow_full = pow_prod >>> POWER_SHIFT;
  wire pow_ovf = pow_full[39:15] != {25{pow_full[15]}};
  wire math_go = state_q == ST_MATH && !mode_wr && cal_q != 16'h0000;

  // sequencer: mode writes restart, steps run in order, cycle ends in math
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_CONV;
      step_q <= STEP_PSHUNT;
      tick_q <= 24'h0;
      samp_q <= 13'h0;
      acc_q <= 28'h0;
    end else if (mode_wr) begin
      tick_q <= 24'h0;
      samp_q <= 13'h0;
      acc_q <= 28'h0;
      if (mode_new[MODE_PD_BIT]) begin
        state_q <= ST_PD;
      end else if (mode_new[MODE_IDLE_BIT]) begin
        state_q <= ST_IDLE;
      end else begin
        state_q <= ST_CONV;
        step_q <= first_new[2:0];
      end
    end else begin
      case (state_q)
        ST_CONV: begin
          if (conv_end) begin
            tick_q <= 24'h0;
            if (last_samp) begin
              acc_q <= 28'h0;
              samp_q <= 13'h0;
              if (nxt[3]) begin
                step_q <= nxt[2:0];
              end else begin
                state_q <= ST_MATH;
              end
            end else begin
              acc_q <= acc_sum;
              samp_q <= samp_q + 13'h1;
            end
          end else begin
            tick_q <= tick_q + 24'h1;
          end
        end
        ST_MATH: begin
          if (mode_q[MODE_CONT_BIT]) begin
            state_q <= ST_CONV;
            step_q <= first_cur[2:0];
          end else begin
            state_q <= mode_q[MODE_POST_BIT] ? ST_PD : ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // converter control outputs follow the sequencer one cycle later
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      converter_power_down_q <= 1'b0;
      conv_busy_q <= 1'b0;
      conv_input_q <= 3'h0;
      sample_take_q <= 1'b0;
    end else begin
      converter_power_down_q <= state_q == ST_PD;
      conv_busy_q <= state_q == ST_CONV || state_q == ST_MATH;
      conv_input_q <= step_q;
      sample_take_q <= conv_end && !mode_wr;
    end
  end

  // result registers, written only with the finished average
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 5; i++) res_q[i] <= 16'h0000;
    end else if (conv_end && last_samp && !mode_wr) begin
      res_q[step_q] <= avg_full[15:0];
    end
  end

  // current and power results with overflow flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      current_result_q <= 16'h0000;
      power_result_q <= 16'h0000;
      math_overflow_flag_q <= 1'b0;
    end else if (math_go) begin
      current_result_q <= cur_full[15:0];
      power_result_q <= pow_full[15:0];
      math_overflow_flag_q <= cur_ovf || pow_ovf;
    end
  end

  // ready flag: cleared by mode write, set at end of a triggered cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conversion_ready_flag_q <= 1'b0;
    end else if (mode_wr) begin
      conversion_ready_flag_q <= 1'b0;
    end else if (state_q == ST_MATH && !mode_q[MODE_CONT_BIT]) begin
      conversion_ready_flag_q <= 1'b1;
    end
  end

  // host-writable configuration
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= MODE_RST;
      cal_q <= CAL_RST;
      icfg_q <= ICFG_RST;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_MODE) mode_q <= mode_new;
      if (reg_addr == ADDR_CAL) cal_q <= reg_wdata & CAL_MASK;
      if (reg_addr == ADDR_ICFG) icfg_q <= reg_wdata & ICFG_MASK;
    end
  end

  // read decode, unmapped addresses read zero
  always_comb begin
    if (reg_addr == ADDR_MODE) rd_val = {8'h00, mode_q};
    else if (reg_addr == ADDR_STAT) rd_val = {14'h0, conversion_ready_flag_q, math_overflow_flag_q};
    else if (reg_addr == ADDR_ICFG) rd_val = icfg_q;
    else if (reg_addr == ADDR_CAL) rd_val = cal_q;
    else if (reg_addr == ADDR_PSHUNT) rd_val = res_q[STEP_PSHUNT];
    else if (reg_addr == ADDR_PBUS) rd_val = res_q[STEP_PBUS];
    else if (reg_addr == ADDR_ASHUNT) rd_val = res_q[STEP_ASHUNT];
    else if (reg_addr == ADDR_ABUS) rd_val = res_q[STEP_ABUS];
    else if (reg_addr == ADDR_TEMP) rd_val = res_q[STEP_TEMP];
    else if (reg_addr == ADDR_CURR) rd_val = current_result_q;
    else if (reg_addr == ADDR_POWR) rd_val = power_result_q;
    else rd_val = 16'h0000;
  end

  // read data register, loaded on each read strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_val;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  pd_on_write_a: assert property (mode_wr && mode_new[MODE_PD_BIT]
    |=> ##1 converter_power_down_q && !conv_busy_q)
    else $error("converter not powered down after write");
  idle_hold_a: assert property (mode_wr && !mode_new[MODE_PD_BIT] && mode_new[MODE_IDLE_BIT]
    |=> ##1 !conv_busy_q && !sample_take_q && !converter_power_down_q)
    else $error("converter acquiring while idle");
  post_trig_a: assert property (state_q == ST_MATH && !mode_wr && !mode_q[MODE_CONT_BIT]
    |=> ##1 converter_power_down_q == $past(mode_q[MODE_POST_BIT], 2))
    else $error("wrong state after triggered cycle");
  trig_start_a: assert property (mode_wr && !mode_new[MODE_PD_BIT] && !mode_new[MODE_IDLE_BIT]
    |=> ##1 conv_busy_q && conv_input_q == $past(first_new[2:0], 2))
    else $error("write did not start a cycle");
  rdy_clear_a: assert property (mode_wr |=> !conversion_ready_flag_q)
    else $error("ready flag not cleared by mode write");
  rdy_rise_a: assert property ($rose(conversion_ready_flag_q)
    |-> $past(state_q == ST_MATH) && !mode_q[MODE_CONT_BIT])
    else $error("ready rose outside end of triggered cycle");
  cont_loop_a: assert property (state_q == ST_MATH && !mode_wr && mode_q[MODE_CONT_BIT]
    |=> state_q == ST_CONV ##1 conv_busy_q)
    else $error("continuous mode stopped cycling");
  input_sel_a: assert property (sample_take_q |-> sel_mask[conv_input_q])
    else $error("sample taken from unselected input");
  step_time_a: assert property (state_q == ST_CONV && $stable(icfg_q)
    |-> tick_q < step_cycles)
    else $error("conversion ran past its step time");
endmodule
`default_nettype wire

/* File: shared/pm_seq_pkg.sv */
// constants, register map and state type for the power monitor converter sequencer
// assumes a 125 MHz system clock and a host-side register port from the serial interface
package pm_seq_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CAL = 8'h38;
  localparam logic [7:0] ADDR_MODE = 8'hD2;
  localparam logic [7:0] ADDR_STAT = 8'hD3;
  localparam logic [7:0] ADDR_ICFG = 8'hD4;
  localparam logic [7:0] ADDR_PSHUNT = 8'hD6;
  localparam logic [7:0] ADDR_PBUS = 8'h8B;
  localparam logic [7:0] ADDR_CURR = 8'h8C;
  localparam logic [7:0] ADDR_POWR = 8'h96;
  localparam logic [7:0] ADDR_ASHUNT = 8'hF0;
  localparam logic [7:0] ADDR_ABUS = 8'hF1;
  localparam logic [7:0] ADDR_TEMP = 8'hF2;
  // reset values and writable-bit masks
  localparam logic [7:0] MODE_RST = 8'h0A;
  localparam logic [7:0] MODE_MASK = 8'h7F;
  localparam logic [15:0] ICFG_RST = 16'h0387;
  localparam logic [15:0] ICFG_MASK = 16'h3FFF;
  localparam logic [15:0] CAL_RST = 16'h0000;
  localparam logic [15:0] CAL_MASK = 16'h7FFF;
  // mode bit positions
  localparam int MODE_PD_BIT = 6;
  localparam int MODE_IDLE_BIT = 5;
  localparam int MODE_POST_BIT = 4;
  localparam int MODE_CONT_BIT = 3;
  // input steps in fixed conversion order
  localparam logic [2:0] STEP_PSHUNT = 3'h0;
  localparam logic [2:0] STEP_PBUS = 3'h1;
  localparam logic [2:0] STEP_ASHUNT = 3'h2;
  localparam logic [2:0] STEP_ABUS = 3'h3;
  localparam logic [2:0] STEP_TEMP = 3'h4;
  // timing: shortest conversion time and clock rate
  localparam int CONV_BASE_US = 64;
  localparam int CLK_MHZ = 125;
  localparam int CONV_BASE_CYCLES = CONV_BASE_US * CLK_MHZ;
  localparam logic [2:0] FIXED_CT_CODE = 3'h7;
  // arithmetic scaling
  localparam logic [3:0] AVG_MAX_SHIFT = 4'hC;
  localparam int MATH_RES_SHIFT = 11;
  localparam int POWER_SHIFT = 12;
  typedef enum logic [1:0] {ST_PD, ST_IDLE, ST_CONV, ST_MATH} state_e;
endpackage

/* File: verif/converter_model.sv */
// converter model: presents a sample for the input that the sequencer is converting
// assumes the sequencer's lagged busy, power-down, input and take outputs on one clock
`timescale 1ns/1ps
`default_nettype none
module converter_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic power_down,
  input wire logic busy,
  input wire logic [2:0] input_sel,
  input wire logic take,
  input wire logic signed [15:0] level_even,
  input wire logic signed [15:0] level_odd,
  input wire logic signed [15:0] step,
  output logic signed [15:0] sample_data
);
  logic alt_q;
  logic [15:0] churn_q;
  logic signed [15:0] level;
  // alternate samples differ by step; churn is junk shown outside conversions
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alt_q <= 1'b0;
      churn_q <= 16'hA5C3;
    end else begin
      churn_q <= {churn_q[14:0], churn_q[15] ^ churn_q[13]};
      if (take) begin
        alt_q <= ~alt_q;
      end
    end
  end
  // odd inputs are bus channels, even ones shunt or temperature
  assign level = input_sel[0] ? level_odd : level_even;
  assign sample_data = (busy && !power_down) ? level + (alt_q ? step : 16'sh0000) : churn_q;
endmodule
`default_nettype wire

/* File: verif/test_power_monitor_adc_sequencer.sv */
// self-checking bench of the converter sequencer, random levels from a fixed seed
// assumes the converter model beside it and a shortened base conversion time
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %0h got %0h", nm, (e), (g)); end end
module test_power_monitor_adc_sequencer
  import pm_seq_pkg::*;
;
  localparam int BASE = 4;
  localparam logic [7:0] MASKS [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1F};
  logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata_q, current_result_q, power_result_q;
  logic signed [15:0] sample_data, lev_e = 16'sh0000, lev_o = 16'sh0000, stp = 16'sh0000;
  logic pd, busy, take, ready, ovf;
  logic [2:0] in_sel, prev_in = 3'h0, last_in = 3'h0;
  logic [7:0] seen = 8'h00;
  int takes = 0, gap = 0, since = 0, order_bad = 0, cyc = 0, err_total = 0, checks = 0;
  always #4 clk = ~clk;
  power_monitor_adc_sequencer #(.conv_base_cycles(BASE)) dut_u (.clk(clk), .nrst(nrst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .sample_data(sample_data), .reg_rdata_q(reg_rdata_q), .converter_power_down_q(pd),
    .conv_busy_q(busy), .conv_input_q(in_sel), .sample_take_q(take),
    .current_result_q(current_result_q), .power_result_q(power_result_q),
    .conversion_ready_flag_q(ready), .math_overflow_flag_q(ovf));
  converter_model conv_u (.clk(clk), .nrst(nrst), .power_down(pd), .busy(busy),
    .input_sel(in_sel), .take(take), .level_even(lev_e), .level_odd(lev_o), .step(stp),
    .sample_data(sample_data));
  task automatic close_out;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // watch sample takes: inputs seen, their order, spacing; cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev_in <= in_sel;
    since <= since + 1;
    if (take) begin
      seen <= seen | (8'h01 << prev_in);
      takes <= takes + 1;
      gap <= since + 1;
      since <= 0;
      order_bad <= order_bad + int'(prev_in < last_in);
      last_in <= prev_in;
    end
    if (cyc == 60000) begin
      err_total++;
      close_out();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  // mode write, then clear the take monitor before any take can land
  task automatic go(input logic [7:0] m);
    wr(ADDR_MODE, {8'h00, m});
    @(negedge clk);
    seen = 8'h00;
    takes = 0;
    last_in = 3'h0;
  endtask
  // one triggered cycle: ready clears, sets, then busy drops and post state shows
  task automatic run(input logic [7:0] m, input int lim);
    int n;
    go(m);
    @(posedge clk);
    #1;
    `CHK("ready_clr", 1'b0, ready)
    n = 0;
    while (ready !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK("ready_set", 1'b1, ready)
    repeat (3) @(posedge clk);
    #1;
    `CHK("busy_end", 1'b0, busy)
    `CHK("post_pd", m[MODE_POST_BIT], pd)
  endtask
  function automatic int ct_cycles(input logic [2:0] c);
    return BASE << (c < 3'h4 ? int'(c) : (c[1] ? 5 : 4));
  endfunction
  initial begin
    logic [15:0] v;
    logic signed [15:0] b, d;
    longint cur, pw;
    int cal;
    void'($urandom(66));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd(ADDR_MODE, v);
    `CHK("mode_rst", 16'h000A, v)
    rd(ADDR_ICFG, v);
    `CHK("icfg_rst", 16'h0387, v)
    rd(ADDR_STAT, v);
    `CHK("stat_rst", 16'h0000, v)
    rd(8'h00, v);
    `CHK("unmapped", 16'h0000, v)
    `CHK("pd_rst", 1'b0, pd)
    wr(ADDR_ICFG, 16'hFFFF);
    rd(ADDR_ICFG, v);
    `CHK("icfg_rsv", 16'h3FFF, v)
    wr(ADDR_CAL, 16'hFFFF);
    rd(ADDR_CAL, v);
    `CHK("cal_rsv", 16'h7FFF, v)
    go(8'hFF);
    repeat (3) @(posedge clk);
    rd(ADDR_MODE, v);
    `CHK("mode_rsv", 16'h007F, v)
    `CHK("pd_on", 1'b1, pd)
    wr(ADDR_STAT, 16'hFFFF);
    rd(ADDR_STAT, v);
    `CHK("stat_ro", 16'h0000, v)
    wr(ADDR_ICFG, 16'h0000);
    go(8'h28);
    repeat (200) @(posedge clk);
    `CHK("idle_takes", 0, takes)
    `CHK("idle_pd", 1'b0, pd)
    go(8'h08);
    repeat (100) @(posedge clk);
    `CHK("cont_runs", 1'b1, takes >= 10)
    `CHK("cont_ready", 1'b0, ready)
    // every input selection, odd ones ending powered down
    for (int m = 0; m < 8; m++) begin
      run(8'(m) | (m[0] ? 8'h10 : 8'h00), 2000);
      `CHK("inputs", MASKS[m], seen)
      `CHK("steps", $countones(MASKS[m]), takes)
      `CHK("order", 0, order_bad)
    end
    // every time code on both shunt channels, two samples averaged
    for (int c = 0; c < 16; c++) begin
      b = 16'($signed($urandom_range(0, 8000)) - 4000);
      d = 16'($urandom_range(0, 100) * 2);
      @(posedge clk);
      lev_e <= b;
      stp <= d;
      wr(ADDR_ICFG, c[3] ? 16'((c % 8) << 7) | 16'h0400 : 16'(c % 8) | 16'h0008);
      run(c[3] ? 8'h03 : 8'h00, 2000);
      `CHK("conv_time", ct_cycles(3'(c)), gap)
      rd(c[3] ? ADDR_ASHUNT : ADDR_PSHUNT, v);
      `CHK("avg2", 16'(b + d / 2), v)
    end
    wr(ADDR_ICFG, 16'h0060);
    run(8'h00, 20000);
    `CHK("avg_max", 4096, takes)
    rd(ADDR_PSHUNT, v);
    `CHK("avg_max_val", 16'(b + d / 2), v)
    // current and power from random gain, then a forced overflow
    wr(ADDR_ICFG, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      b = k == 3 ? 16'sd16000 : 16'($signed($urandom_range(0, 4000)) - 2000);
      cal = k == 3 ? 32767 : $urandom_range(1, 32767);
      @(posedge clk);
      lev_e <= b;
      lev_o <= 16'($urandom_range(0, 4095));
      stp <= 16'sh0000;
      wr(ADDR_CAL, 16'(cal));
      run(8'h02, 2000);
      cur = (longint'(b) * cal) >>> 11;
      pw = (cur * longint'(lev_o)) >>> 12;
      `CHK("ovf", k == 3, ovf)
      rd(ADDR_STAT, v);
      `CHK("stat_done", (k == 3) ? 16'h0003 : 16'h0002, v)
      if (k < 3) begin
        `CHK("cur_port", 16'(cur), current_result_q)
        `CHK("pow_port", 16'(pw), power_result_q)
        rd(ADDR_CURR, v);
        `CHK("current", 16'(cur), v)
        rd(ADDR_POWR, v);
        `CHK("power", 16'(pw), v)
      end
    end
    close_out();
  end
endmodule
`default_nettype wire
